// ==== verilog/sample_fifo_irq_status.sv ====
// sample fifo interrupt enables, fill target and status flag logic
//
// Behaviour
// - bit 11 gates low-limit flag onto interrupt; resets to 0.
// - bit 10 gates overrun flag onto interrupt; resets to 0.
// - bit 9 gates fill-target flag; resets to 1.
// - bit 8 gates empty flag onto interrupt; resets to 0.
// - empty interrupt follows empty flag with no extra latency.
// - bit 12 gates high-limit flag onto interrupt; resets to 0.
// - 8-bit fill-target field in control low byte, resets zero.
// - fill target 0 means 256 samples; 1..255 literal.
// - mode 00 off, 01 hold-first, 10/11 keep-newest.
// - flags 4:0 set only in hold-first or keep-newest mode; error bit 7 ignores mode.
// - status at 0x3B reads 0x01 after reset, read-only.
// - status bit 7 is OR of device error register.
// - controller-error bit also drives main status error bit.
//
// Implementation choice: strobed register access.
`default_nettype none
module sample_fifo_irq_status
    import fifo_irq_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [23:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [23:0] RDATA,
    input  wire logic [8:0]  FIFO_LEVEL,
    input  wire logic        LOW_LIMIT_HIT,
    input  wire logic        HIGH_LIMIT_HIT,
    input  wire logic        OVERRUN_HIT,
    input  wire logic [7:0]  DEVICE_ERRORS,
    output logic             FIFO_IRQ,
    output logic             MAIN_CTRL_ERR,
    output logic             IRQ
);
    // ========================================
    // register port
    reg_req_type   req;
    logic [23:0]   control_q;
    logic [7:0]    status_q;
    logic [NUM_EVT-1:0] evt_stat_q;
    logic [NUM_EVT-1:0] evt_mask_q;
    logic [23:0]   rdata_q;
    fifo_mode_type mode;
    logic          mode_active;
    logic [8:0]    fill_count;
    logic          fill_reached;
    flag_set_type  flags;
    flag_set_type  enables;
    logic [NUM_EVT-1:0] flags_prev_q;
    logic [NUM_EVT-1:0] rise;
    logic          dev_err_s1_q;
    logic          dev_err_s2_q;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            control_q <= CONTROL_RESET & 24'h03FF00;
        end else if (req.wr && req.addr == ADDR_CONTROL) begin
            // bit 15 kept zero; upper byte bits above mode reserved
            control_q <= req.wdata & 24'h037FFF;
        end
    end

    assign enables = '{high:  control_q[EN_HIGH_BIT],
                       low:   control_q[EN_LOW_BIT],
                       ovr:   control_q[EN_OVR_BIT],
                       fill:  control_q[EN_FILL_BIT],
                       empty: control_q[EN_EMPTY_BIT]};

    mode_decode u_mode (
        .field  (control_q[MODE_LSB+1:MODE_LSB]),
        .mode   (mode),
        .active (mode_active)
    );

    fill_target_decode u_fill (
        .target  (control_q[7:0]),
        .level   (FIFO_LEVEL),
        .count   (fill_count),
        .reached (fill_reached)
    );

    // ========================================
    // status flags
    // device error summary crosses in from another block's pins
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            dev_err_s1_q <= 1'b0;
            dev_err_s2_q <= 1'b0;
        end else begin
            dev_err_s1_q <= |DEVICE_ERRORS;
            dev_err_s2_q <= dev_err_s1_q;
        end
    end

    always_comb begin
        flags.high  = mode_active & HIGH_LIMIT_HIT;
        flags.low   = mode_active & LOW_LIMIT_HIT;
        flags.ovr   = mode_active & OVERRUN_HIT;
        flags.fill  = mode_active & fill_reached;
        flags.empty = mode_active & (FIFO_LEVEL == 9'h000);
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= {dev_err_s2_q, 2'b00, flags.high, flags.low,
                         flags.ovr, flags.fill, flags.empty};
        end
    end

    assign MAIN_CTRL_ERR = status_q[FLAG_CERR];

    assign FIFO_IRQ = |(flags & enables);

    // ========================================
    // sticky event status and mask
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            flags_prev_q <= '0;
        end else begin
            flags_prev_q <= flags;
        end
    end
    assign rise = flags & ~flags_prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
            // set wins over write-one-clear
            always_ff @(posedge SYS_CLK) begin
                if (!RST_N) begin
                    evt_stat_q[gi] <= 1'b0;
                end else if (rise[gi]) begin
                    evt_stat_q[gi] <= 1'b1;
                end else if (req.wr && req.addr == ADDR_IRQ_STAT
                             && req.wdata[gi]) begin
                    evt_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            evt_mask_q <= '0;
        end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
            evt_mask_q <= req.wdata[NUM_EVT-1:0];
        end
    end

    assign IRQ = |(evt_stat_q & evt_mask_q);

    // ========================================
    // read back, one cycle later; unmapped reads zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_STATUS:   rdata_q <= {16'h0000, status_q};
                ADDR_CONTROL:  rdata_q <= control_q;
                ADDR_IRQ_STAT: rdata_q <= {19'h00000, evt_stat_q};
                ADDR_IRQ_MASK: rdata_q <= {19'h00000, evt_mask_q};
                default:       rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign RDATA = rdata_q;

    // ========================================
    // checks
    property p_fill_reset;
        @(posedge SYS_CLK) $rose(RST_N) |->
            control_q[EN_FILL_BIT] && !control_q[EN_EMPTY_BIT]
            && (control_q[7:0] == 8'h00);
    endproperty
    a_fill_reset: assert property (p_fill_reset)
        else $error("fill enable not set after reset");

    property p_empty_irq;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (flags.empty && enables.empty) |-> FIFO_IRQ;
    endproperty
    a_empty_irq: assert property (p_empty_irq)
        else $error("empty irq late");

    property p_low_gate;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (!control_q[EN_LOW_BIT] && !control_q[EN_HIGH_BIT]
             && !control_q[EN_OVR_BIT] && !control_q[EN_FILL_BIT]
             && !control_q[EN_EMPTY_BIT]) |-> !FIFO_IRQ;
    endproperty
    a_low_gate: assert property (p_low_gate)
        else $error("irq while all enables off");

    property p_off_quiet;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (control_q[17:16] == 2'b00) |=> (status_q[4:0] == 5'h00);
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("flag set while fifo disabled");

    property p_fill_count;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (control_q[7:0] == 8'h00) |-> (fill_count == 9'h100);
    endproperty
    a_fill_count: assert property (p_fill_count)
        else $error("target zero not 256");

    property p_ctrl_err;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (|DEVICE_ERRORS) ##1 (|DEVICE_ERRORS) ##1 (|DEVICE_ERRORS)
            |=> status_q[FLAG_CERR] && MAIN_CTRL_ERR;
    endproperty
    a_ctrl_err: assert property (p_ctrl_err)
        else $error("controller error summary missing");

    property p_status_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (RD && ADDR == ADDR_STATUS) |=> (RDATA[7:0] == $past(status_q));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read mismatch");

    property p_disable_drop;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (flags == flags_prev_q && (flags & enables) == 5'h00)
            |-> !FIFO_IRQ;
    endproperty
    a_disable_drop: assert property (p_disable_drop)
        else $error("irq without enabled flag");

    property p_sticky;
        @(posedge SYS_CLK) disable iff (!RST_N)
            rise[FLAG_OVR] |=> evt_stat_q[FLAG_OVR];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overrun event lost");

    c_empty_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        flags.empty && enables.empty);
    c_fill_hit: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        flags.fill && FIFO_IRQ);
    c_irq_out: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        IRQ);
endmodule : sample_fifo_irq_status
`default_nettype wire

// ==== verilog/fifo_irq_pkg.sv ====
// package: register map, field positions, reset values and types for the block
`default_nettype none
package fifo_irq_pkg;
    localparam logic [7:0]  ADDR_STATUS      = 8'h3B;
    localparam logic [7:0]  ADDR_CONTROL     = 8'h3A;
    localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h40;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h41;
    localparam logic [23:0] CONTROL_RESET    = 24'h040200;
    localparam logic [7:0]  STATUS_RESET     = 8'h01;
    localparam int          EN_HIGH_BIT      = 12;
    localparam int          EN_LOW_BIT       = 11;
    localparam int          EN_OVR_BIT       = 10;
    localparam int          EN_FILL_BIT      = 9;
    localparam int          EN_EMPTY_BIT     = 8;
    localparam int          MODE_LSB         = 16;
    localparam int          FLAG_CERR        = 7;
    localparam int          FLAG_HIGH        = 4;
    localparam int          FLAG_LOW         = 3;
    localparam int          FLAG_OVR         = 2;
    localparam int          FLAG_FILL        = 1;
    localparam int          FLAG_EMPTY       = 0;
    localparam logic [8:0]  FULL_DEPTH       = 9'h100;
    localparam int          NUM_EVT          = 5;

    typedef enum logic [1:0] {
        MODE_OFF, MODE_HOLD, MODE_NEWEST
    } fifo_mode_type;

    typedef struct packed {
        logic high;
        logic low;
        logic ovr;
        logic fill;
        logic empty;
    } flag_set_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [23:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;
endpackage : fifo_irq_pkg
`default_nettype wire

// ==== verilog/fill_target_decode.sv ====
// fill-target decode: 8-bit field to sample count and reached flag
`default_nettype none
module fill_target_decode
    import fifo_irq_pkg::*;
(
    input  wire logic [7:0] target,
    input  wire logic [8:0] level,
    output logic      [8:0] count,
    output logic            reached
);
    assign count   = (target == 8'h00) ? FULL_DEPTH : {1'b0, target};
    assign reached = (level >= count);
endmodule : fill_target_decode
`default_nettype wire

// ==== verilog/mode_decode.sv ====
// fifo mode field decode
`default_nettype none
module mode_decode
    import fifo_irq_pkg::*;
(
    input  wire logic [1:0]    field,
    output fifo_mode_type      mode,
    output logic               active
);
    always_comb begin
        case (field)
            2'h0:    mode = MODE_OFF;
            2'h1:    mode = MODE_HOLD;
            default: mode = MODE_NEWEST;
        endcase
    end
    assign active = (mode != MODE_OFF);
endmodule : mode_decode
`default_nettype wire

// ==== sim/host_model.sv ====
// host model: register bus master with one-cycle strobes
`default_nettype none
module host_model (
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [23:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [23:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr  = 8'h00;
        wdata = 24'h000000;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // ========================================
    // bus cycles
    // target one never written
    task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // released lines never keep the old value
        addr  <= ~a;
        wdata <= ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [23:0] d);
        @(posedge clk);
        rd_now(a, d);
    endtask : rd_reg
    // caller stands just after a rising edge, so the strobe goes up at once
    task automatic rd_now(input logic [7:0] a, output logic [23:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : rd_now
endmodule : host_model
`default_nettype wire

// ==== sim/sample_fifo_irq_status_bench.sv ====
// self-checking bench for the fifo interrupt and status block
`default_nettype none
module sample_fifo_irq_status_bench
    import fifo_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
    logic [23:0] rdata;
    logic [8:0]  level   = 9'h005;
    logic        lo      = 1'b0;
    logic        hi      = 1'b0;
    logic        ov      = 1'b0;
    logic [7:0]  dev_err = 8'h00;
    logic        fifo_irq;
    logic        main_err;
    logic        irq;
    int          n_mismatch = 0;
    int          checked    = 0;
    always #4 sys_clk = ~sys_clk;
    host_model h (.clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    sample_fifo_irq_status dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .FIFO_LEVEL(level), .LOW_LIMIT_HIT(lo), .HIGH_LIMIT_HIT(hi),
        .OVERRUN_HIT(ov), .DEVICE_ERRORS(dev_err), .FIFO_IRQ(fifo_irq),
        .MAIN_CTRL_ERR(main_err), .IRQ(irq));
    // ========================================
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [23:0] ctl(input logic [1:0] m,
        input logic [4:0] e, input logic [7:0] t);
        return {6'h00, m, 3'h0, e, t};
    endfunction : ctl
    task automatic set_in(input logic [8:0] l, input logic [2:0] f);
        @(posedge sys_clk);
        level <= l;
        {hi, lo, ov} <= f;
    endtask : set_in
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // ========================================
    // scenarios
    task automatic t_reset();
        logic [23:0] d;
        // read rides the release edge: reset value stands one cycle only
        h.rd_now(ADDR_STATUS, d);
        chk(d, 24'h000001);
        h.rd_reg(ADDR_CONTROL, d);
        chk(d & 24'h00FFFF, 24'h000200);
        h.wr_reg(ADDR_CONTROL, 24'hFC8200);
        h.wr_reg(8'h55, 24'hFFFFFF);
        h.rd_reg(ADDR_CONTROL, d);
        chk(d, 24'h000200);
        h.rd_reg(8'h55, d);
        chk(d, 24'h000000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_enables();
        logic [23:0] d;
        logic [7:0]  t;
        for (int i = 0; i < NUM_EVT; i++) begin
            t = (i == 1) ? 8'h05 : 8'h06;
            set_in((i == 0) ? 9'h000 : 9'h005, {i == 4, i == 3, i == 2});
            h.wr_reg(ADDR_CONTROL, ctl(2'b01, 5'(1 << i), t));
            #1;
            chk(24'(fifo_irq), 24'h000001);
            h.wr_reg(ADDR_CONTROL, ctl(2'b01, ~5'(1 << i), t));
            #1;
            chk(24'(fifo_irq), 24'h000000);
            h.rd_reg(ADDR_STATUS, d);
            chk(d, 24'(1 << i));
        end
        $display("test enables done");
    endtask : t_enables
    task automatic t_mode();
        logic [23:0] d;
        set_in(9'h000, 3'b111);
        for (int m = 0; m < 4; m++) begin
            h.wr_reg(ADDR_CONTROL, ctl(2'(m), 5'h1F, 8'h06));
            #1;
            chk(24'(fifo_irq), 24'(m != 0));
            h.rd_reg(ADDR_STATUS, d);
            chk(d, (m != 0) ? 24'h00001D : 24'h000000);
        end
        $display("test mode done");
    endtask : t_mode
    task automatic t_fill();
        // target 0 is the full depth, so 255 stored must not count
        for (int k = 0; k < 4; k++) begin
            set_in((k < 2 ? 9'h0FF : 9'h0FE) + 9'(k % 2), 3'b000);
            h.wr_reg(ADDR_CONTROL,
                ctl(2'b10, 5'h02, (k < 2) ? 8'h00 : 8'hFF));
            #1;
            chk(24'(fifo_irq), 24'(k % 2));
        end
        $display("test fill done");
    endtask : t_fill
    task automatic t_err();
        logic [23:0] d;
        for (int e = 1; e >= 0; e--) begin
            @(posedge sys_clk);
            dev_err <= (e == 1) ? 8'h10 : 8'h00;
            repeat (5) @(posedge sys_clk);
            h.rd_reg(ADDR_STATUS, d);
            chk(d & 24'h000080, 24'(e * 8'h80));
            chk(24'(main_err), 24'(e));
        end
        $display("test error done");
    endtask : t_err
    task automatic t_sticky();
        logic [23:0] d;
        set_in(9'h005, 3'b000);
        h.wr_reg(ADDR_CONTROL, ctl(2'b01, 5'h01, 8'h06));
        h.wr_reg(ADDR_IRQ_STAT, 24'h00001F);
        h.wr_reg(ADDR_IRQ_MASK, 24'h000001);
        h.rd_reg(ADDR_IRQ_STAT, d);
        chk(d, 24'h000000);
        set_in(9'h000, 3'b000);
        #1;
        chk(24'(fifo_irq), 24'h000001);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(24'(irq), 24'h000001);
        h.wr_reg(ADDR_IRQ_MASK, 24'h000000);
        #1;
        chk(24'(irq), 24'h000000);
        h.wr_reg(ADDR_IRQ_MASK, 24'h000001);
        h.wr_reg(ADDR_IRQ_STAT, 24'h000001);
        h.rd_reg(ADDR_IRQ_STAT, d);
        chk(d, 24'h000000);
        chk(24'(irq), 24'h000000);
        $display("test sticky done");
    endtask : t_sticky
    // ========================================
    // main sequence and hang guard
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_enables();
        t_mode();
        t_fill();
        t_err();
        t_sticky();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        $display("mismatch at %0t: run too long", $time);
        close_out();
    end
endmodule : sample_fifo_irq_status_bench
`default_nettype wire
